// ### pwmoe_fault_in.sv
// Fault-input detector: falling edge or sixteen low samples
`timescale 1ns/1ns
`include "pwmoe_regs.svh"
module pwmoe_fault_in import pwmoe_pkg::*; #(
  parameter int CNT_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  pwmoe_if.det     dif
);
  pwmoe_det_st_t    st_r;
  pwmoe_det_st_t    st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             prev_r;
  logic             tick;
  logic             edge_mode;

  assign edge_mode = (dif.mode == PWMOE_MODE_EDGE);

  always_comb begin
    case (dif.mode)
      PWMOE_MODE_DIV8:   tick = dif.tick8;
      PWMOE_MODE_DIV16:  tick = dif.tick16;
      PWMOE_MODE_DIV128: tick = dif.tick128;
      default:           tick = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      PWMOE_DET_ARMED: begin
        if (edge_mode) begin
          if (prev_r && !dif.fault_n) st_nxt = PWMOE_DET_TRIPPED;
        end else if (tick && !dif.fault_n) begin
          cnt_nxt = CNT_W'(1);
          st_nxt  = PWMOE_DET_COUNTING;
        end
      end
      PWMOE_DET_COUNTING: begin
        if (edge_mode || (tick && dif.fault_n)) begin
          st_nxt  = PWMOE_DET_ARMED;
          cnt_nxt = '0;
        end else if (tick) begin
          if (cnt_r == CNT_W'(`PWMOE_LVL_SAMPLES - 5'h01)) st_nxt = PWMOE_DET_TRIPPED;
          else cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      PWMOE_DET_TRIPPED: begin
        // Level mode stays tripped while the pin is low, so a clear cannot take early
        if (edge_mode || dif.fault_n) begin
          st_nxt  = PWMOE_DET_ARMED;
          cnt_nxt = '0;
        end
      end
      default: begin
        st_nxt  = PWMOE_DET_ARMED;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= PWMOE_DET_ARMED;
      cnt_r  <= '0;
      prev_r <= 1'b1;
    end else if (ce) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      prev_r <= dif.fault_n;
    end
  end

  assign dif.detect = (st_r == PWMOE_DET_TRIPPED);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_EDGE_TRIP: assert property ((ce && edge_mode && st_r == PWMOE_DET_ARMED && prev_r
    && !dif.fault_n) |=> dif.detect) else $error("falling edge not detected");
  AST_LVL_NEEDS_LOW: assert property ((!edge_mode && $rose(dif.detect)) |->
    !$past(dif.fault_n)) else $error("level trip without low sample");
endmodule // pwmoe_fault_in

// ### pwmoe_if.sv
// Link between the top and one fault-input detector
`timescale 1ns/1ns
interface pwmoe_if import pwmoe_pkg::*; ();
  logic        tick8;
  logic        tick16;
  logic        tick128;
  pwmoe_mode_t mode;
  logic        fault_n;
  logic        detect;
  modport det (input tick8, input tick16, input tick128, input mode, input fault_n,
               output detect);
  modport ctl (output tick8, output tick16, output tick128, output mode,
               output fault_n, input detect);
endinterface

// ### pwmoe_pkg.sv
// Types shared by the output-disable block
package pwmoe_pkg;
  typedef enum logic [1:0] {
    PWMOE_MODE_EDGE   = 2'h0,
    PWMOE_MODE_DIV8   = 2'h1,
    PWMOE_MODE_DIV16  = 2'h2,
    PWMOE_MODE_DIV128 = 2'h3
  } pwmoe_mode_t;
  typedef enum logic [2:0] {
    PWMOE_DET_ARMED    = 3'h1,
    PWMOE_DET_COUNTING = 3'h2,
    PWMOE_DET_TRIPPED  = 3'h4
  } pwmoe_det_st_t;
endpackage

// ### pwmoe_regs.svh
// Register offsets, field positions, reset values and sampling counts
`ifndef PWMOE_REGS_SVH
`define PWMOE_REGS_SVH
`define PWMOE_OFS_FCTRL   8'h00
`define PWMOE_OFS_SWREQ   8'h04
`define PWMOE_OFS_CH0EN   8'h08
`define PWMOE_OFS_PAIREN  8'h0C
`define PWMOE_OFS_STAT    8'h10
`define PWMOE_OFS_MASK    8'h14
`define PWMOE_OFS_ALVL    8'h18
`define PWMOE_OFS_CMPSEL  8'h1C
`define PWMOE_OFS_CMPFLG  8'h20
`define PWMOE_FC_IRQEN    8
`define PWMOE_SW_PAIR     0
`define PWMOE_SW_CH0      2
`define PWMOE_PE_4BD      8
`define PWMOE_PE_4AC      9
`define PWMOE_PE_3BD      10
`define PWMOE_ST_SHORT    3
`define PWMOE_ST_OSC      4
`define PWMOE_ST_CMP      5
`define PWMOE_RST_FCTRL   16'h0000
`define PWMOE_RST_SWREQ   8'h00
`define PWMOE_RST_CH0EN   8'hFF
`define PWMOE_RST_PAIREN  3'h7
`define PWMOE_RST_MASK    6'h00
`define PWMOE_RST_ALVL    6'h3F
`define PWMOE_DIV8_LAST   3'h7
`define PWMOE_DIV16_LAST  4'hF
`define PWMOE_DIV128_LAST 7'h7F
`define PWMOE_LVL_SAMPLES 5'h10
`endif

// ### pwmoe_timer_model.sv
// Behavioural model of the timer outputs that feed the disable block
`timescale 1ns/1ns
module pwmoe_timer_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] short_sel,
  output logic      [3:0] timer_ch0_out,
  output logic      [3:0] timer_ch0_oe,
  output logic      [5:0] timer_pair_out,
  output logic      [5:0] timer_pair_oe
);
  logic [3:0] cnt_r;
  logic       p;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign p             = cnt_r[0];
  assign timer_ch0_out = cnt_r;
  assign timer_ch0_oe  = 4'hF;
  assign timer_pair_oe = 6'h3F;
  // Pairs stay complementary so only a commanded short trips detection
  always_comb begin
    timer_pair_out = {~p, ~p, p, p, ~p, p};
    case (short_sel)
      2'h1: timer_pair_out = timer_pair_out | 6'h03;
      2'h2: timer_pair_out = timer_pair_out | 6'h14;
      2'h3: timer_pair_out = timer_pair_out | 6'h28;
      default: ;
    endcase
  end
endmodule // pwmoe_timer_model

// ### pwmoe_top.sv
// Emergency output disable for the timer PWM pins, APB slave
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "pwmoe_regs.svh"
module pwmoe_top import pwmoe_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int NCMP   = 2
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              fault_input_a_n,
  input  wire logic              fault_input_b_n,
  input  wire logic              fault_input_c_n,
  input  wire logic              osc_stop,
  input  wire logic [NCMP-1:0]   cmp_detect,
  input  wire logic [3:0]        timer_ch0_out,
  input  wire logic [3:0]        timer_ch0_oe,
  input  wire logic [5:0]        timer_pair_out,
  input  wire logic [5:0]        timer_pair_oe,
  output logic      [7:0]        pad_ch0_out,
  output logic      [7:0]        pad_ch0_oe,
  output logic      [5:0]        pad_pair_out,
  output logic      [5:0]        pad_pair_oe,
  output logic                   irq
);
  logic [15:0]     fctrl_r;
  logic [15:0]     fctrl_nxt;
  logic [7:0]      sw_r;
  logic [7:0]      sw_nxt;
  logic [7:0]      ch0en_r;
  logic [7:0]      ch0en_nxt;
  logic [2:0]      pairen_r;
  logic [2:0]      pairen_nxt;
  logic [4:0]      st_r;
  logic [4:0]      st_nxt;
  logic [5:0]      mask_r;
  logic [5:0]      mask_nxt;
  logic [5:0]      alvl_r;
  logic [5:0]      alvl_nxt;
  logic [NCMP-1:0] cmpsel_r;
  logic [NCMP-1:0] cmpsel_nxt;
  logic [NCMP-1:0] cmpflg_r;
  logic [NCMP-1:0] cmpflg_nxt;
  logic [31:0]     prdata_r;
  logic [31:0]     prdata_nxt;
  logic            irq_r;
  logic            irq_nxt;
  logic [6:0]      pre_r;
  logic [6:0]      pre_nxt;
  logic [7:0]      pch0_out_r;
  logic [7:0]      pch0_oe_r;
  logic [5:0]      ppair_out_r;
  logic [5:0]      ppair_oe_r;
  logic [7:0]      pch0_oe_nxt;
  logic [5:0]      ppair_oe_nxt;
  logic [2:0]      fault_det;
  logic [2:0]      fault_pins_n;
  logic [5:0]      act;
  logic            short_now;
  logic [5:0]      st_all;
  logic [5:0]      pend;
  logic            latched_any;
  logic            ch0_req;
  logic            pair_req;
  logic [7:0]      ch0_hiz;
  logic [5:0]      pair_hiz;
  logic            wr;
  logic            setup;
  logic            hit;
  logic [7:0]      a8;
  logic            tick8;
  logic            tick16;
  logic            tick128;

  // Shared prescaler: one counter serves all three sample rates
  always_comb begin
    pre_nxt = pre_r + 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 7'h00;
    end else if (ce) begin
      pre_r <= pre_nxt;
    end
  end

  assign tick8   = (pre_r[2:0] == `PWMOE_DIV8_LAST);
  assign tick16  = (pre_r[3:0] == `PWMOE_DIV16_LAST);
  assign tick128 = (pre_r == `PWMOE_DIV128_LAST);

  pwmoe_if fif [3] ();
  assign fault_pins_n = {fault_input_c_n, fault_input_b_n, fault_input_a_n};

  for (genvar g = 0; g < 3; g++) begin : g_det
    assign fif[g].tick8   = tick8;
    assign fif[g].tick16  = tick16;
    assign fif[g].tick128 = tick128;
    assign fif[g].mode    = pwmoe_mode_t'(fctrl_r[2*g+1 -: 2]);
    assign fif[g].fault_n = fault_pins_n[g];
    assign fault_det[g]   = fif[g].detect;
    pwmoe_fault_in #(.CNT_W(5)) u_det (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .dif     (fif[g])
    );
  end

  // Pair order: 0=3B 1=3D 2=4A 3=4B 4=4C 5=4D
  assign act       = ~(timer_pair_out ^ alvl_r) & timer_pair_oe;
  assign short_now = (act[0] & act[1]) | (act[2] & act[4]) | (act[3] & act[5]);

  // APB: zero wait states while ce is high, read data captured in the setup cycle
  assign a8     = 8'(paddr);
  assign setup  = ce && psel && !penable;
  assign wr     = ce && psel && penable && pwrite;
  assign pready = ce;
  always_comb begin
    case (a8)
      `PWMOE_OFS_FCTRL, `PWMOE_OFS_SWREQ, `PWMOE_OFS_CH0EN, `PWMOE_OFS_PAIREN,
      `PWMOE_OFS_STAT, `PWMOE_OFS_MASK, `PWMOE_OFS_ALVL, `PWMOE_OFS_CMPSEL,
      `PWMOE_OFS_CMPFLG: hit = (paddr == ADDR_W'(a8));
      default:           hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  assign st_all = {|cmpflg_r, st_r};
  assign pend   = st_all & mask_r & {3'h7, {3{fctrl_r[`PWMOE_FC_IRQEN]}}};

  always_comb begin
    fctrl_nxt  = fctrl_r;
    sw_nxt     = sw_r;
    ch0en_nxt  = ch0en_r;
    pairen_nxt = pairen_r;
    mask_nxt   = mask_r;
    alvl_nxt   = alvl_r;
    cmpsel_nxt = cmpsel_r;
    prdata_nxt = prdata_r;
    if (wr) begin
      case (a8)
        `PWMOE_OFS_FCTRL:  fctrl_nxt  = {7'h00, pwdata[8], 2'h0, pwdata[5:0]};
        `PWMOE_OFS_SWREQ:  sw_nxt     = {5'h00, pwdata[`PWMOE_SW_CH0], 1'b0,
                                         pwdata[`PWMOE_SW_PAIR]};
        `PWMOE_OFS_CH0EN:  ch0en_nxt  = pwdata[7:0];
        `PWMOE_OFS_PAIREN: pairen_nxt = pwdata[`PWMOE_PE_3BD:`PWMOE_PE_4BD];
        `PWMOE_OFS_MASK:   mask_nxt   = pwdata[5:0];
        `PWMOE_OFS_ALVL:   alvl_nxt   = pwdata[5:0];
        `PWMOE_OFS_CMPSEL: cmpsel_nxt = pwdata[NCMP-1:0];
        default: ;
      endcase
    end
    // Sticky status: a new event in the clearing cycle beats the clear
    st_nxt = (st_r & ~((wr && a8 == `PWMOE_OFS_STAT) ? pwdata[4:0] : 5'h00))
             | {osc_stop, short_now, fault_det};
    cmpflg_nxt = (cmpflg_r & ~((wr && a8 == `PWMOE_OFS_CMPFLG) ? pwdata[NCMP-1:0]
                 : {NCMP{1'b0}})) | (cmp_detect & cmpsel_r);
    irq_nxt = |pend;
    if (setup) begin
      case (a8)
        `PWMOE_OFS_FCTRL:  prdata_nxt = {16'h0000, fctrl_r};
        `PWMOE_OFS_SWREQ:  prdata_nxt = {24'h000000, sw_r};
        `PWMOE_OFS_CH0EN:  prdata_nxt = {24'h000000, ch0en_r};
        `PWMOE_OFS_PAIREN: prdata_nxt = {21'h000000, pairen_r, 8'h00};
        `PWMOE_OFS_STAT:   prdata_nxt = {26'h0000000, st_all};
        `PWMOE_OFS_MASK:   prdata_nxt = {26'h0000000, mask_r};
        `PWMOE_OFS_ALVL:   prdata_nxt = {26'h0000000, alvl_r};
        `PWMOE_OFS_CMPSEL: prdata_nxt = 32'(cmpsel_r);
        `PWMOE_OFS_CMPFLG: prdata_nxt = 32'(cmpflg_r);
        default:           prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fctrl_r  <= `PWMOE_RST_FCTRL;
      sw_r     <= `PWMOE_RST_SWREQ;
      ch0en_r  <= `PWMOE_RST_CH0EN;
      pairen_r <= `PWMOE_RST_PAIREN;
      st_r     <= 5'h00;
      mask_r   <= `PWMOE_RST_MASK;
      alvl_r   <= `PWMOE_RST_ALVL;
      cmpsel_r <= {NCMP{1'b0}};
      cmpflg_r <= {NCMP{1'b0}};
      prdata_r <= 32'h00000000;
      irq_r    <= 1'b0;
    end else if (ce) begin
      fctrl_r  <= fctrl_nxt;
      sw_r     <= sw_nxt;
      ch0en_r  <= ch0en_nxt;
      pairen_r <= pairen_nxt;
      st_r     <= st_nxt;
      mask_r   <= mask_nxt;
      alvl_r   <= alvl_nxt;
      cmpsel_r <= cmpsel_nxt;
      cmpflg_r <= cmpflg_nxt;
      prdata_r <= prdata_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // Any latched source disables every pin whose enable bit is set
  assign latched_any = |st_all;
  assign ch0_req     = latched_any | sw_r[`PWMOE_SW_CH0];
  assign pair_req    = latched_any | sw_r[`PWMOE_SW_PAIR];
  assign ch0_hiz     = ch0en_r & {8{ch0_req}};
  assign pair_hiz    = {pairen_r[0], pairen_r[1], pairen_r[0], pairen_r[1],
                        pairen_r[2], pairen_r[2]} & {6{pair_req}};

  // Pads are registered, so a disable reaches the pins one cycle after it latches
  always_comb begin
    pch0_oe_nxt  = {2{timer_ch0_oe}} & ~ch0_hiz;
    ppair_oe_nxt = timer_pair_oe & ~pair_hiz;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pch0_out_r  <= 8'h00;
      pch0_oe_r   <= 8'h00;
      ppair_out_r <= 6'h00;
      ppair_oe_r  <= 6'h00;
    end else if (ce) begin
      pch0_out_r  <= {2{timer_ch0_out}};
      pch0_oe_r   <= pch0_oe_nxt;
      ppair_out_r <= timer_pair_out;
      ppair_oe_r  <= ppair_oe_nxt;
    end
  end

  assign pad_ch0_out  = pch0_out_r;
  assign pad_ch0_oe   = pch0_oe_r;
  assign pad_pair_out = ppair_out_r;
  assign pad_pair_oe  = ppair_oe_r;
  assign prdata       = prdata_r;
  assign irq          = irq_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_HIZ_PINS: assert property (ce |=> ((pad_ch0_oe & $past(ch0_hiz)) == 8'h00 &&
    (pad_pair_oe & $past(pair_hiz)) == 6'h00)) else $error("pin driven while disabled");
  AST_FAULT_ALL: assert property ((ce && |fault_det && &ch0en_r && &pairen_r) |=> ##1
    (pad_ch0_oe == 8'h00 && pad_pair_oe == 6'h00)) else $error("fault left a pin on");
  AST_SHORT_SET: assert property ((ce && short_now) |=> st_r[`PWMOE_ST_SHORT])
    else $error("short not latched");
  AST_OSC_SET: assert property ((ce && osc_stop) |=> st_r[`PWMOE_ST_OSC] && latched_any)
    else $error("oscillator stop not latched");
  AST_CMP_SEL: assert property ((ce && |(cmp_detect & cmpsel_r)) |=> |cmpflg_r)
    else $error("selected comparator not flagged");
  AST_CMP_IGN: assert property ((ce && cmpflg_r == '0 &&
    (cmp_detect & cmpsel_r) == '0 && !wr) |=> cmpflg_r == '0)
    else $error("unselected comparator flagged");
  AST_SW_CH0: assert property ((ce && sw_r[`PWMOE_SW_CH0] && ch0en_r[0]) |=>
    !pad_ch0_oe[0]) else $error("software disable ignored");
  AST_CH0_LOC: assert property ((ce && !ch0en_r[4] && timer_ch0_oe[0]) |=>
    pad_ch0_oe[4]) else $error("disabled enable bit still cut pin");
  AST_PAIR_BD: assert property ((ce && sw_r[`PWMOE_SW_PAIR] && pairen_r[0]) |=>
    (!pad_pair_oe[3] && !pad_pair_oe[5])) else $error("ch4 B/D pair not disabled");
  AST_IRQ_FLT: assert property ((ce && st_r[0] && mask_r[0] && !fctrl_r[`PWMOE_FC_IRQEN]
    && st_r[4:1] == 4'h0 && mask_r[5:1] == 5'h00) |=> !irq) else $error("fault irq ungated");
  AST_HOLD: assert property ((ce && st_r[`PWMOE_ST_OSC] &&
    !(wr && a8 == `PWMOE_OFS_STAT)) |=> st_r[`PWMOE_ST_OSC])
    else $error("status dropped without clear");

  COV_FAULT: cover property (ce && |fault_det ##1 latched_any);
  COV_SHORT: cover property (ce && short_now ##2 pad_pair_oe == 6'h00);
  COV_IRQ:   cover property ($rose(irq));
  COV_CLEAR: cover property (st_r != 5'h00 ##[1:20] st_r == 5'h00);
endmodule // pwmoe_top

// ### tb_top.sv
// Self-checking bench for the output-disable block
`timescale 1ns/1ns
`include "pwmoe_regs.svh"
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  fault_n;
  logic        osc_stop;
  logic [1:0]  cmp_detect;
  logic [1:0]  short_sel;
  logic [3:0]  t0_out;
  logic [3:0]  t0_oe;
  logic [5:0]  tp_out;
  logic [5:0]  tp_oe;
  logic [7:0]  pad_ch0_out;
  logic [7:0]  pad_ch0_oe;
  logic [5:0]  pad_pair_out;
  logic [5:0]  pad_pair_oe;
  logic        irq;
  int          fails;
  int          checks_done;
  int          cycles;
  // Resolved level of one pad, so a disabled pin is seen floating
  wire         pin_ch0_a = pad_ch0_oe[0] ? pad_ch0_out[0] : 1'bz;

  pwmoe_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_input_a_n(fault_n[0]), .fault_input_b_n(fault_n[1]),
    .fault_input_c_n(fault_n[2]), .osc_stop(osc_stop), .cmp_detect(cmp_detect),
    .timer_ch0_out(t0_out), .timer_ch0_oe(t0_oe), .timer_pair_out(tp_out),
    .timer_pair_oe(tp_oe), .pad_ch0_out(pad_ch0_out), .pad_ch0_oe(pad_ch0_oe),
    .pad_pair_out(pad_pair_out), .pad_pair_oe(pad_pair_oe), .irq(irq));
  pwmoe_timer_model u_tmr (.pclk(pclk), .presetn(presetn), .short_sel(short_sel),
    .timer_ch0_out(t0_out), .timer_ch0_oe(t0_oe), .timer_pair_out(tp_out),
    .timer_pair_oe(tp_oe));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Ceiling well above the few thousand cycles the scenarios need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      $display("mismatch %0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the global timeout ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp, "read data");
    chk({31'h0, err}, {31'h0, eerr}, "slave error");
  endtask

  // Looks at settled outputs mid-cycle, then returns on a rising edge for the next stimulus
  task automatic pads_chk(input logic [7:0] c0, input logic [5:0] pr);
    @(negedge pclk);
    chk({24'h0, pad_ch0_oe}, {24'h0, c0}, "ch0 pad enable");
    chk({26'h0, pad_pair_oe}, {26'h0, pr}, "pair pad enable");
    @(posedge pclk);
  endtask

  task automatic irq_chk(input logic e, input string msg);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e}, msg);
    @(posedge pclk);
  endtask

  task automatic t_reset_values();
    rd_chk(`PWMOE_OFS_FCTRL, 32'h0, 1'b0);
    rd_chk(`PWMOE_OFS_SWREQ, 32'h0, 1'b0);
    rd_chk(`PWMOE_OFS_CH0EN, 32'h0000_00FF, 1'b0);
    rd_chk(`PWMOE_OFS_PAIREN, 32'h0000_0700, 1'b0);
    rd_chk(`PWMOE_OFS_MASK, 32'h0, 1'b0);
    rd_chk(`PWMOE_OFS_ALVL, 32'h0000_003F, 1'b0);
    rd_chk(`PWMOE_OFS_CMPSEL, 32'h0, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
  endtask

  task automatic t_pass_through();
    logic [3:0] c;
    logic [5:0] q;
    @(negedge pclk);
    c = t0_out;
    q = tp_out;
    @(negedge pclk);
    chk({24'h0, pad_ch0_out}, {24'h0, c, c}, "ch0 pads follow timer");
    chk({26'h0, pad_pair_out}, {26'h0, q}, "pair pads follow timer");
    pads_chk(8'hFF, 6'h3F);
  endtask

  task automatic t_software();
    wr(`PWMOE_OFS_SWREQ, 32'h4);
    wait_cyc(2);
    pads_chk(8'h00, 6'h3F);
    chk({31'h0, pin_ch0_a}, {31'h0, 1'bz}, "pin floats");
    wr(`PWMOE_OFS_SWREQ, 32'h1);
    wait_cyc(2);
    pads_chk(8'hFF, 6'h00);
    wr(`PWMOE_OFS_PAIREN, 32'h100);
    wait_cyc(2);
    pads_chk(8'hFF, 6'h17);
    wr(`PWMOE_OFS_CH0EN, 32'h0F);
    wr(`PWMOE_OFS_SWREQ, 32'h4);
    wait_cyc(2);
    pads_chk(8'hF0, 6'h3F);
    wr(`PWMOE_OFS_SWREQ, 32'h0);
    wr(`PWMOE_OFS_CH0EN, 32'hFF);
    wr(`PWMOE_OFS_PAIREN, 32'h700);
    wait_cyc(2);
    pads_chk(8'hFF, 6'h3F);
  endtask

  task automatic t_fault_edge();
    fault_n[0] <= 1'b0;
    wait_cyc(5);
    pads_chk(8'h00, 6'h00);
    rd_chk(`PWMOE_OFS_STAT, 32'h1, 1'b0);
    wr(`PWMOE_OFS_MASK, 32'h1);
    wait_cyc(3);
    irq_chk(1'b0, "fault irq gated off");
    wr(`PWMOE_OFS_FCTRL, 32'h100);
    wait_cyc(3);
    irq_chk(1'b1, "fault irq");
    fault_n[0] <= 1'b1;
    wait_cyc(4);
    pads_chk(8'h00, 6'h00);
    wr(`PWMOE_OFS_STAT, 32'h1);
    wait_cyc(3);
    pads_chk(8'hFF, 6'h3F);
    irq_chk(1'b0, "irq drops");
    wr(`PWMOE_OFS_MASK, 32'h0);
  endtask

  task automatic t_fault_level(input int idx, input logic [31:0] fc,
                               input int t_lo, input int t_more);
    wr(`PWMOE_OFS_FCTRL, fc);
    fault_n[idx] <= 1'b0;
    wait_cyc(t_lo);
    rd_chk(`PWMOE_OFS_STAT, 32'h0, 1'b0);
    wait_cyc(t_more);
    rd_chk(`PWMOE_OFS_STAT, 32'h1 << idx, 1'b0);
    pads_chk(8'h00, 6'h00);
    wr(`PWMOE_OFS_STAT, 32'h1 << idx);
    rd_chk(`PWMOE_OFS_STAT, 32'h1 << idx, 1'b0);
    fault_n[idx] <= 1'b1;
    wait_cyc(4);
    wr(`PWMOE_OFS_STAT, 32'h1 << idx);
    rd_chk(`PWMOE_OFS_STAT, 32'h0, 1'b0);
  endtask

  task automatic t_short();
    wr(`PWMOE_OFS_MASK, 32'h8);
    for (int s = 1; s <= 3; s++) begin
      short_sel <= s[1:0];
      wait_cyc(4);
      pads_chk(8'h00, 6'h00);
      irq_chk(1'b1, "short irq");
      short_sel <= 2'h0;
      rd_chk(`PWMOE_OFS_STAT, 32'h8, 1'b0);
      wr(`PWMOE_OFS_STAT, 32'h8);
      wait_cyc(3);
      pads_chk(8'hFF, 6'h3F);
    end
    // With 3B/3D active low, both pins high is no short
    wr(`PWMOE_OFS_ALVL, 32'h3C);
    short_sel <= 2'h1;
    wait_cyc(4);
    rd_chk(`PWMOE_OFS_STAT, 32'h0, 1'b0);
    short_sel <= 2'h0;
    wr(`PWMOE_OFS_ALVL, 32'h3F);
    wr(`PWMOE_OFS_MASK, 32'h0);
  endtask

  // Clock enable low freezes the detectors, so a fault edge waits for ce
  task automatic t_clock_enable();
    ce <= 1'b0;
    fault_n[0] <= 1'b0;
    wait_cyc(4);
    pads_chk(8'hFF, 6'h3F);
    ce <= 1'b1;
    wait_cyc(4);
    pads_chk(8'h00, 6'h00);
    fault_n[0] <= 1'b1;
    wr(`PWMOE_OFS_STAT, 32'h1);
    rd_chk(`PWMOE_OFS_STAT, 32'h0, 1'b0);
  endtask

  task automatic t_osc_cmp();
    osc_stop <= 1'b1;
    wait_cyc(4);
    pads_chk(8'h00, 6'h00);
    wr(`PWMOE_OFS_STAT, 32'h10);
    rd_chk(`PWMOE_OFS_STAT, 32'h10, 1'b0);
    osc_stop <= 1'b0;
    wait_cyc(2);
    wr(`PWMOE_OFS_STAT, 32'h10);
    cmp_detect <= 2'h1;
    wait_cyc(4);
    rd_chk(`PWMOE_OFS_CMPFLG, 32'h0, 1'b0);
    rd_chk(`PWMOE_OFS_STAT, 32'h0, 1'b0);
    wr(`PWMOE_OFS_CMPSEL, 32'h1);
    wait_cyc(4);
    pads_chk(8'h00, 6'h00);
    rd_chk(`PWMOE_OFS_CMPFLG, 32'h1, 1'b0);
    rd_chk(`PWMOE_OFS_STAT, 32'h20, 1'b0);
    cmp_detect <= 2'h0;
    wait_cyc(2);
    wr(`PWMOE_OFS_CMPFLG, 32'h1);
    rd_chk(`PWMOE_OFS_STAT, 32'h0, 1'b0);
    wait_cyc(2);
    pads_chk(8'hFF, 6'h3F);
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    cycles = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fault_n = 3'h7;
    osc_stop = 1'b0;
    cmp_detect = 2'h0;
    short_sel = 2'h0;
    wait_cyc(8);
    presetn <= 1'b1;
    t_reset_values();
    t_pass_through();
    t_software();
    t_fault_edge();
    t_fault_level(0, 32'h2, 200, 150);
    t_fault_level(1, 32'h4, 100, 100);
    t_fault_level(2, 32'h30, 1800, 600);
    t_short();
    t_osc_cmp();
    t_clock_enable();
    tally_and_finish();
  end
endmodule // tb_top
